//--- verilog/lsw_regs.sv
/*
 * control and status registers of load switches four to seven, with the
 * current-limit time-out timers.
 * assumes the host interface decoder presents a byte register port on
 * clk_sys, and status inputs come from the analog switches, unsynchronised.
 */
`timescale 1ns/10ps
`include "lsw_defs.svh"

// Summary of operation
// - wait code 00/01/10/11 gives 200/800/1600/3200 us minimum limit time-out.
// - bit 7 reads 1 once the switch overran its current-limited wait time.
// - bits 6 and 5 read overcurrent and overtemperature detection of the switch.
// - bit 4 reads 1 while the switch output voltage is good.
// - bit 1 is read-write auto-discharge enable, reset to 1.
module lsw_regs #(
	parameter int WAIT0_CYCLES = `LSW_WAIT0_CYC,
	parameter int WAIT1_CYCLES = `LSW_WAIT1_CYC,
	parameter int WAIT2_CYCLES = `LSW_WAIT2_CYC,
	parameter int WAIT3_CYCLES = `LSW_WAIT3_CYC,
	parameter int CNT_W = 20
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [3:0] sw_limit_in,
	input wire logic [3:0] sw_overcurrent_in,
	input wire logic [3:0] sw_overtemp_in,
	input wire logic [3:0] sw_power_good_in,
	output logic [3:0] sw_switch_on,
	output logic [3:0] sw_discharge_enable
);
	import lsw_pkg::*;

	localparam int NSW = 4;

	// refuse counter widths the timers cannot use
	if (CNT_W < 2 || CNT_W > 30)
	begin : g_bad_width
		$error("lsw_regs: counter width out of range");
	end

	// writable fields and sticky time-out flags
	logic [NSW-1:0] switch_enable_reg;
	logic [NSW-1:0] discharge_enable_reg;
	lsw_wait_t wait_select_reg [NSW];
	logic [NSW-1:0] timeout_flag_reg;
	logic [NSW-1:0] timeout_set;

	// synchroniser stages of the analog status inputs
	logic [3:0] limit_meta_reg, limit_sync_reg;
	logic [3:0] oc_meta_reg, oc_sync_reg;
	logic [3:0] ot_meta_reg, ot_sync_reg;
	logic [3:0] pg_meta_reg, pg_sync_reg;

	// read data ahead of its register
	logic [7:0] rdata_next;

	// offset to switch slot; bit 2 marks a hit
	function automatic logic [2:0] decode(input logic [7:0] addr);
		unique case (addr)
			`LSW_OFS_SW4: decode = 3'h4;
			`LSW_OFS_SW5: decode = 3'h5;
			`LSW_OFS_SW6: decode = 3'h6;
			`LSW_OFS_SW7: decode = 3'h7;
			default: decode = 3'h0;
		endcase
	endfunction : decode

	// current-limit synchroniser, first stage read only by the second
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			limit_meta_reg <= '0;
			limit_sync_reg <= '0;
		end
		else
		begin
			limit_meta_reg <= sw_limit_in;
			limit_sync_reg <= limit_meta_reg;
		end
	end

	// overcurrent synchroniser
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			oc_meta_reg <= '0;
			oc_sync_reg <= '0;
		end
		else
		begin
			oc_meta_reg <= sw_overcurrent_in;
			oc_sync_reg <= oc_meta_reg;
		end
	end

	// overtemperature synchroniser
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			ot_meta_reg <= '0;
			ot_sync_reg <= '0;
		end
		else
		begin
			ot_meta_reg <= sw_overtemp_in;
			ot_sync_reg <= ot_meta_reg;
		end
	end

	// power-good synchroniser
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			pg_meta_reg <= '0;
			pg_sync_reg <= '0;
		end
		else
		begin
			pg_meta_reg <= sw_power_good_in;
			pg_sync_reg <= pg_meta_reg;
		end
	end

	// per switch: writable fields, time-out flag and timer
	for (genvar i = 0; i < NSW; i++)
	begin : g_sw
		lsw_sw_if sw_bus ();
		logic hit_wr;

		assign hit_wr = reg_wr && (decode(reg_addr) == 3'(4 + i));
		assign sw_bus.enable = switch_enable_reg[i];
		assign sw_bus.wait_sel = wait_select_reg[i];
		assign sw_bus.in_limit = limit_sync_reg[i];
		assign timeout_set[i] = sw_bus.timeout_pulse;

		// writable control fields
		always_ff @(posedge clk_sys or posedge reset)
		begin
			if (reset)
			begin
				switch_enable_reg[i] <= `LSW_RST_ENABLE;
				discharge_enable_reg[i] <= `LSW_RST_DISCHARGE;
				wait_select_reg[i] <= `LSW_RST_WAIT;
			end
			else if (hit_wr)
			begin
				switch_enable_reg[i] <= reg_wdata[`LSW_BIT_ENABLE];
				discharge_enable_reg[i] <= reg_wdata[`LSW_BIT_DISCHARGE];
				wait_select_reg[i] <= reg_wdata[`LSW_BIT_WAIT_HI:`LSW_BIT_WAIT_LO];
			end
		end

		// time-out flag: set by the timer, cleared by a register write, set wins
		always_ff @(posedge clk_sys or posedge reset)
		begin
			if (reset)
				timeout_flag_reg[i] <= 1'b0;
			else if (timeout_set[i])
				timeout_flag_reg[i] <= 1'b1;
			else if (hit_wr)
				timeout_flag_reg[i] <= 1'b0;
		end

		lsw_timeout_timer #(
			.CNT_W(CNT_W),
			.WAIT0_CYCLES(WAIT0_CYCLES),
			.WAIT1_CYCLES(WAIT1_CYCLES),
			.WAIT2_CYCLES(WAIT2_CYCLES),
			.WAIT3_CYCLES(WAIT3_CYCLES)
		) u_timer (
			.clk_sys(clk_sys),
			.reset(reset),
			.sw(sw_bus.tmr)
		);
	end

	// switch drive: a timed-out switch stays off until rewritten
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			sw_switch_on <= '0;
			sw_discharge_enable <= {NSW{`LSW_RST_DISCHARGE}};
		end
		else
		begin
			sw_switch_on <= switch_enable_reg & ~timeout_flag_reg & ~timeout_set;
			sw_discharge_enable <= discharge_enable_reg;
		end
	end

	// read data assembly; unmapped offsets read zero
	always_comb
	begin
		logic [2:0] slot;
		slot = decode(reg_addr);
		rdata_next = 8'h00;
		if (slot[2])
		begin
			rdata_next[`LSW_BIT_TIMEOUT] = timeout_flag_reg[slot[1:0]];
			rdata_next[`LSW_BIT_OVERCURRENT] = oc_sync_reg[slot[1:0]];
			rdata_next[`LSW_BIT_OVERTEMP] = ot_sync_reg[slot[1:0]];
			rdata_next[`LSW_BIT_POWER_GOOD] = pg_sync_reg[slot[1:0]];
			rdata_next[`LSW_BIT_WAIT_HI:`LSW_BIT_WAIT_LO] = wait_select_reg[slot[1:0]];
			rdata_next[`LSW_BIT_DISCHARGE] = discharge_enable_reg[slot[1:0]];
			rdata_next[`LSW_BIT_ENABLE] = switch_enable_reg[slot[1:0]];
		end
	end

	// read data register, updated on a read strobe
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			reg_rdata <= 8'h00;
		else if (reg_rd)
			reg_rdata <= rdata_next;
	end
endmodule : lsw_regs

//--- verilog/lsw_defs.svh
/*
 * constants of the load switch control register bank: offsets, field
 * positions, reset value and time-out wait figures.
 * assumes inclusion by bare name from the package and the design modules.
 */
`ifndef LSW_DEFS_SVH
`define LSW_DEFS_SVH

// register offsets on the host register port
`define LSW_OFS_SW4 8'h12
`define LSW_OFS_SW5 8'h13
`define LSW_OFS_SW6 8'h14
`define LSW_OFS_SW7 8'h15

// field positions inside each switch register
`define LSW_BIT_TIMEOUT 7
`define LSW_BIT_OVERCURRENT 6
`define LSW_BIT_OVERTEMP 5
`define LSW_BIT_POWER_GOOD 4
`define LSW_BIT_WAIT_HI 3
`define LSW_BIT_WAIT_LO 2
`define LSW_BIT_DISCHARGE 1
`define LSW_BIT_ENABLE 0

// reset values of the writable fields
`define LSW_RST_WAIT 2'h0
`define LSW_RST_DISCHARGE 1'b1
`define LSW_RST_ENABLE 1'b0

// clock rate and minimum current-limited wait times
`define LSW_CLK_MHZ 100
`define LSW_WAIT0_US 200
`define LSW_WAIT1_US 800
`define LSW_WAIT2_US 1600
`define LSW_WAIT3_US 3200
`define LSW_WAIT0_CYC (`LSW_WAIT0_US * `LSW_CLK_MHZ)
`define LSW_WAIT1_CYC (`LSW_WAIT1_US * `LSW_CLK_MHZ)
`define LSW_WAIT2_CYC (`LSW_WAIT2_US * `LSW_CLK_MHZ)
`define LSW_WAIT3_CYC (`LSW_WAIT3_US * `LSW_CLK_MHZ)

`endif

//--- verilog/lsw_pkg.sv
/*
 * types of the load switch control register bank.
 * assumes lsw_defs.svh is on the include path.
 */
`include "lsw_defs.svh"

package lsw_pkg;
	// wait time selection code
	typedef logic [1:0] lsw_wait_t;
	// time-out timer states
	typedef enum logic [1:0] {
		LSW_TMR_IDLE,
		LSW_TMR_COUNT,
		LSW_TMR_TRIPPED
	} lsw_tmr_state_e;
endpackage : lsw_pkg

//--- verilog/lsw_sw_if.sv
/*
 * carrier between the register bank and one switch time-out timer.
 * assumes both ends run on clk_sys.
 */
`timescale 1ns/10ps

interface lsw_sw_if;
	logic enable;
	lsw_pkg::lsw_wait_t wait_sel;
	logic in_limit;
	logic timeout_pulse;
	modport ctl (output enable, output wait_sel, output in_limit, input timeout_pulse);
	modport tmr (input enable, input wait_sel, input in_limit, output timeout_pulse);
endinterface : lsw_sw_if

//--- verilog/lsw_timeout_timer.sv
/*
 * current-limit time-out timer of one load switch.
 * assumes in_limit is already synchronised to clk_sys.
 */
`timescale 1ns/10ps
`include "lsw_defs.svh"

module lsw_timeout_timer #(
	parameter int CNT_W = 20,
	parameter int WAIT0_CYCLES = `LSW_WAIT0_CYC,
	parameter int WAIT1_CYCLES = `LSW_WAIT1_CYC,
	parameter int WAIT2_CYCLES = `LSW_WAIT2_CYC,
	parameter int WAIT3_CYCLES = `LSW_WAIT3_CYC
) (
	input wire logic clk_sys,
	input wire logic reset,
	lsw_sw_if.tmr sw
);
	import lsw_pkg::*;

	// refuse widths and counts that the counter cannot hold
	if (CNT_W < 2 || CNT_W > 30 || WAIT0_CYCLES < 1 || WAIT1_CYCLES < 1 || WAIT2_CYCLES < 1
		|| WAIT3_CYCLES < 1 || WAIT0_CYCLES >= (1 << CNT_W) || WAIT1_CYCLES >= (1 << CNT_W)
		|| WAIT2_CYCLES >= (1 << CNT_W) || WAIT3_CYCLES >= (1 << CNT_W))
	begin : g_bad_count
		$error("lsw_timeout_timer: wait counts do not fit the counter");
	end

	lsw_tmr_state_e state_reg;
	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] limit;
	logic expire;

	// wait code to cycle count
	function automatic logic [CNT_W-1:0] wait_cycles(input lsw_wait_t code);
		unique case (code)
			2'h0: wait_cycles = CNT_W'(WAIT0_CYCLES);
			2'h1: wait_cycles = CNT_W'(WAIT1_CYCLES);
			2'h2: wait_cycles = CNT_W'(WAIT2_CYCLES);
			2'h3: wait_cycles = CNT_W'(WAIT3_CYCLES);
		endcase
	endfunction : wait_cycles

	assign limit = wait_cycles(sw.wait_sel);
	assign expire = (state_reg == LSW_TMR_COUNT) && sw.enable && sw.in_limit
		&& (cnt_reg >= limit - CNT_W'(1));
	assign sw.timeout_pulse = expire;

	// limit episode tracking, restarts whenever the limit condition drops
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			state_reg <= LSW_TMR_IDLE;
		end
		else
		begin
			unique case (state_reg)
				LSW_TMR_IDLE:
					if (sw.enable && sw.in_limit)
						state_reg <= LSW_TMR_COUNT;
				LSW_TMR_COUNT:
					if (!sw.enable || !sw.in_limit)
						state_reg <= LSW_TMR_IDLE;
					else if (expire)
						state_reg <= LSW_TMR_TRIPPED;
				LSW_TMR_TRIPPED:
					if (!sw.enable || !sw.in_limit)
						state_reg <= LSW_TMR_IDLE;
				// unused fourth code of the state word
				default:
					state_reg <= LSW_TMR_IDLE;
			endcase
		end
	end

	// cycles spent in current limit, cleared outside counting
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			cnt_reg <= '0;
		else if (state_reg == LSW_TMR_COUNT && !expire)
			cnt_reg <= cnt_reg + CNT_W'(1);
		else
			cnt_reg <= '0;
	end
endmodule : lsw_timeout_timer

//--- tb/lsw_regs_sva.sv
/* port checker of the load switch register bank, switch four watched.
   assumes binding into lsw_regs on clk_sys. */
`timescale 1ns/10ps
module lsw_regs_sva #(
	parameter int WAIT0_CYCLES = 10,
	parameter int WAIT3_CYCLES = 160
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic [3:0] sw_limit_in,
	input wire logic [3:0] sw_overcurrent_in,
	input wire logic [3:0] sw_overtemp_in,
	input wire logic [3:0] sw_power_good_in,
	input wire logic [3:0] sw_switch_on,
	input wire logic [3:0] sw_discharge_enable
);
	logic armed;
	logic [31:0] lim_cnt;
	wire logic sw4_wr = reg_wr && reg_addr == 8'h12;
	wire logic [2:0] st_now = {sw_overcurrent_in[0], sw_overtemp_in[0], sw_power_good_in[0]};
	default clocking dc @(posedge clk_sys);
	endclocking
	default disable iff (reset);
	// limit cycles while on; a clear with limit high disarms until it drops
	always_ff @(posedge clk_sys or posedge reset)
		if (reset)
			{armed, lim_cnt} <= {1'b1, 32'h0};
		else
			{armed, lim_cnt} <= {!sw_limit_in[0] || (armed && !sw4_wr),
				(sw_limit_in[0] && sw_switch_on[0] && armed) ? lim_cnt + 32'h1 : 32'h0};
	AST_WRITE_DISCHARGE: assert property (sw4_wr ##1 !reg_wr
		|=> sw_discharge_enable[0] == $past(reg_wdata[1], 2)) else $error("discharge");
	AST_WRITE_OFF: assert property (sw4_wr && !reg_wdata[0] ##1 !reg_wr
		|=> !sw_switch_on[0]) else $error("switch not off");
	AST_TRIP_BOUND: assert property (lim_cnt > WAIT3_CYCLES + 8
		|-> !sw_switch_on[0]) else $error("no time-out");
	AST_MIN_WAIT: assert property ($fell(sw_switch_on[0]) && !$past(reg_wr)
		&& !$past(reg_wr, 2) |-> lim_cnt >= WAIT0_CYCLES) else $error("early time-out");
	AST_STATUS_FAULT: assert property (reg_rd && reg_addr == 8'h12 && st_now == $past(st_now)
		&& st_now == $past(st_now, 2) && st_now == $past(st_now, 3)
		|=> reg_rdata[6:5] == $past(st_now[2:1])) else $error("fault bits");
	AST_STATUS_GOOD: assert property (reg_rd && reg_addr == 8'h12 && st_now == $past(st_now)
		&& st_now == $past(st_now, 2) && st_now == $past(st_now, 3)
		|=> reg_rdata[4] == $past(st_now[0])) else $error("power good bit");
endmodule : lsw_regs_sva

bind lsw_regs lsw_regs_sva #(.WAIT0_CYCLES(WAIT0_CYCLES), .WAIT3_CYCLES(WAIT3_CYCLES)) u_sva (
	.clk_sys, .reset, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .sw_limit_in,
	.sw_overcurrent_in, .sw_overtemp_in, .sw_power_good_in, .sw_switch_on,
	.sw_discharge_enable);

//--- tb/tb_top.sv
/* bench of the load switch register bank.
   assumes lsw_regs with short wait counts and its bound checker. */
`timescale 1ns/10ps
module tb_top;
	localparam int w_cyc [4] = '{10, 40, 80, 160};
	logic clk_sys = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rd_val;
	logic [3:0] sw_limit_in = 4'h0, sw_overcurrent_in = 4'h0, sw_overtemp_in = 4'h0;
	logic [3:0] sw_power_good_in = 4'h0, sw_switch_on, sw_discharge_enable;
	int err_count = 0, total_checks = 0;
	always #5 clk_sys = ~clk_sys;
	lsw_regs #(.WAIT0_CYCLES(w_cyc[0]), .WAIT1_CYCLES(w_cyc[1]), .WAIT2_CYCLES(w_cyc[2]),
		.WAIT3_CYCLES(w_cyc[3])) dut (.clk_sys, .reset, .reg_addr, .reg_wr, .reg_wdata,
		.reg_rd, .reg_rdata, .sw_limit_in, .sw_overcurrent_in, .sw_overtemp_in,
		.sw_power_good_in, .sw_switch_on, .sw_discharge_enable);
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// one write, taken at the second edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		{reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr
	// one read, data sampled mid-cycle after the taking edge
	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys);
		{reg_addr, reg_rd} <= {a, 1'b1};
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		rd_val = reg_rdata;
	endtask : rd
	task automatic end_sim;
		if (err_count == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_sim
	// reset values, outputs and an unmapped read
	task automatic t_reset;
		for (int i = 0; i < 4; i++)
		begin
			rd(8'h12 + i[7:0]);
			chk(rd_val, 8'h02);
		end
		chk({sw_discharge_enable, sw_switch_on}, 8'hf0);
		rd(8'h16);
		chk(rd_val, 8'h00);
	endtask : t_reset
	// writable fields and read-only upper bits of each switch
	task automatic t_rw;
		for (int i = 0; i < 4; i++)
		begin
			wr(8'h12 + i[7:0], 8'hff);
			rd(8'h12 + i[7:0]);
			chk(rd_val, 8'h0f);
			chk({6'h0, sw_switch_on[i], sw_discharge_enable[i]}, 8'h03);
			wr(8'h12 + i[7:0], 8'h00);
			rd(8'h12 + i[7:0]);
			chk({rd_val[3:0], 2'h0, sw_switch_on[i], sw_discharge_enable[i]}, 8'h00);
		end
	endtask : t_rw
	// status flags of one switch, neighbour must stay clear
	task automatic t_status;
		for (int i = 0; i < 4; i++)
			for (int p = 1; p < 8; p++)
			begin
				@(posedge clk_sys);
				sw_overcurrent_in <= p[2] ? 4'h1 << i : 4'h0;
				sw_overtemp_in <= p[1] ? 4'h1 << i : 4'h0;
				sw_power_good_in <= p[0] ? 4'h1 << i : 4'h0;
				repeat (2) @(posedge clk_sys);
				rd(8'h12 + i[7:0]);
				chk(rd_val, {1'b0, p[2:0], 4'h0});
				rd(8'h12 + i[7:0] ^ 8'h01);
				chk(rd_val, 8'h00);
			end
		@(posedge clk_sys);
		{sw_overcurrent_in, sw_overtemp_in, sw_power_good_in} <= 12'h000;
	endtask : t_status
	// every wait code, one per switch: trip time, sticky flag, clear
	task automatic t_wait;
		int n;
		for (int c = 0; c < 4; c++)
		begin
			wr(8'h12 + c[7:0], {4'h0, c[1:0], 2'b11});
			repeat (2) @(negedge clk_sys);
			chk({7'h0, sw_switch_on[c]}, 8'h01);
			@(posedge clk_sys);
			sw_limit_in <= 4'h1 << c;
			n = 0;
			while (sw_switch_on[c] !== 1'b0 && n < 400)
			begin
				@(negedge clk_sys);
				n++;
			end
			chk({7'h0, n >= w_cyc[c] + 2 && n <= w_cyc[c] + 8}, 8'h01);
			rd(8'h12 + c[7:0]);
			chk(rd_val, {4'h8, c[1:0], 2'b11});
			@(posedge clk_sys);
			sw_limit_in <= 4'h0;
			wr(8'h12 + c[7:0], 8'h00);
			rd(8'h12 + c[7:0]);
			chk(rd_val, 8'h00);
		end
	endtask : t_wait
	initial
	begin
		#200000;
		err_count++;
		end_sim();
	end
	initial
	begin
		repeat (20) @(posedge clk_sys);
		reset <= 1'b0;
		t_reset();
		t_rw();
		t_status();
		t_wait();
		end_sim();
	end
endmodule : tb_top
